// *** rtom_top.sv ***
`include "rtom_map.svh"
`default_nettype none
module rtom_top #(
  parameter int NUM_PINS = 3
) (
  input  wire logic                sys_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic      [31:0]         prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o,
  input  wire logic [7:0]          preamble_quality_indicator_i,
  input  wire logic [7:0]          received_signal_strength_i,
  input  wire logic                rx_packet_active_i,
  input  wire logic                crc_check_done_i,
  input  wire logic                crc_check_pass_i,
  input  wire logic                rx_mode_start_i,
  input  wire logic [1:0]          rx_decided_bits_i,
  input  wire logic                rx_symbol_tick_i,
  input  wire logic                radio_in_tx_i,
  input  wire logic                radio_in_rx_i,
  input  wire logic [NUM_PINS-1:0] periph_out_i,
  input  wire logic [NUM_PINS-1:0] periph_oe_i,
  input  wire logic [NUM_PINS-1:0] pin_in_i,
  output logic      [NUM_PINS-1:0] pin_out_o,
  output logic      [NUM_PINS-1:0] pin_oe_o
);
  // Index 0 is port 1 bit 5, index 2 is port 1 bit 7
  logic [5:0]                 test_output_select_reg [NUM_PINS];
  logic [NUM_PINS-1:0]        test_output_invert_reg;
  logic [7:0]                 pqt_reg;
  logic [7:0]                 received_signal_strength_thr_reg;
  rtom_pkg::rtom_cca_type     channel_assessment_mode_reg;
  logic [NUM_PINS-1:0]        fsel_reg;
  logic [NUM_PINS-1:0]        dir_reg;
  logic [NUM_PINS-1:0]        dout_reg;
  logic                       crc_ok_reg;
  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic [NUM_PINS-1:0]        pin_out_reg;
  logic [NUM_PINS-1:0]        pin_oe_reg;
  logic [NUM_PINS-1:0]        pin_out_next;
  logic [NUM_PINS-1:0]        pin_oe_next;
  logic [`RTOM_NUM_FLAGS-1:0] flags;
  logic                       access;
  logic                       wr_fire;
  logic                       mapped;
  logic                       pq_flag;
  logic                       cs_flag;
  logic                       below_flag;
  logic                       cca_flag;
  logic [31:0]                rd_value;

  // Zero-wait would need combinational pready; one extra cycle keeps it a flop
  assign access  = psel_i & penable_i & ~pready_reg;
  assign wr_fire = psel_i & penable_i & pready_reg & pwrite_i;

  always_comb
  begin
    mapped   = 1'b1;
    rd_value = 32'h0000_0000;
    case (paddr_i)
      `RTOM_OFS_PIN0_CFG, `RTOM_OFS_PIN1_CFG, `RTOM_OFS_PIN2_CFG:
      begin
        rd_value[`RTOM_CFG_SEL_LSB +: 6] = test_output_select_reg[paddr_i[3:2]];
        rd_value[`RTOM_CFG_INV_BIT]      = test_output_invert_reg[paddr_i[3:2]];
      end
      `RTOM_OFS_THRESH:
      begin
        rd_value[`RTOM_TH_PQT_LSB +: 8]  = pqt_reg;
        rd_value[`RTOM_TH_RECEIVED_SIGNAL_STRENGTH_LSB +: 8] = received_signal_strength_thr_reg;
        rd_value[`RTOM_TH_CCA_LSB +: 2]  = channel_assessment_mode_reg;
      end
      `RTOM_OFS_PORT_CTRL:
      begin
        rd_value[`RTOM_PC_FSEL_LSB +: NUM_PINS] = fsel_reg;
        rd_value[`RTOM_PC_DIR_LSB +: NUM_PINS]  = dir_reg;
        rd_value[`RTOM_PC_DOUT_LSB +: NUM_PINS] = dout_reg;
      end
      `RTOM_OFS_STATUS:
      begin
        rd_value[`RTOM_NUM_FLAGS-1:0]          = flags;
        rd_value[`RTOM_ST_PIN_LSB +: NUM_PINS] = pin_in_i;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end
    else
    begin
      pready_reg  <= access;
      pslverr_reg <= access & ~mapped;
      prdata_reg  <= (access & ~pwrite_i) ? rd_value : 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        test_output_select_reg[i] <= `RTOM_RST_SEL;
      end
      test_output_invert_reg <= '0;
    end
    else if (wr_fire && paddr_i[11:4] == 8'h00 && paddr_i[3:2] != 2'h3 &&
             paddr_i[1:0] == 2'h0)
    begin
      test_output_select_reg[paddr_i[3:2]] <= pwdata_i[`RTOM_CFG_SEL_LSB +: 6];
      test_output_invert_reg[paddr_i[3:2]] <= pwdata_i[`RTOM_CFG_INV_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pqt_reg      <= `RTOM_RST_PQT;
      received_signal_strength_thr_reg <= `RTOM_RST_RECEIVED_SIGNAL_STRENGTH_TH;
      channel_assessment_mode_reg <= rtom_pkg::RTOM_CCA_ALWAYS;
    end
    else if (wr_fire && paddr_i == `RTOM_OFS_THRESH)
    begin
      pqt_reg      <= pwdata_i[`RTOM_TH_PQT_LSB +: 8];
      received_signal_strength_thr_reg <= pwdata_i[`RTOM_TH_RECEIVED_SIGNAL_STRENGTH_LSB +: 8];
      channel_assessment_mode_reg <= rtom_pkg::rtom_cca_type'(pwdata_i[`RTOM_TH_CCA_LSB +: 2]);
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fsel_reg <= `RTOM_RST_PORT;
      dir_reg  <= `RTOM_RST_PORT;
      dout_reg <= `RTOM_RST_PORT;
    end
    else if (wr_fire && paddr_i == `RTOM_OFS_PORT_CTRL)
    begin
      fsel_reg <= pwdata_i[`RTOM_PC_FSEL_LSB +: NUM_PINS];
      dir_reg  <= pwdata_i[`RTOM_PC_DIR_LSB +: NUM_PINS];
      dout_reg <= pwdata_i[`RTOM_PC_DOUT_LSB +: NUM_PINS];
    end
  end

  // Strength and its threshold are two's complement
  assign pq_flag    = preamble_quality_indicator_i > pqt_reg;
  assign cs_flag    = $signed(received_signal_strength_i) > $signed(received_signal_strength_thr_reg);
  assign below_flag = $signed(received_signal_strength_i) < $signed(received_signal_strength_thr_reg);

  always_comb
  begin
    case (channel_assessment_mode_reg)
      rtom_pkg::RTOM_CCA_ALWAYS: cca_flag = 1'b1;
      rtom_pkg::RTOM_CCA_RECEIVED_SIGNAL_STRENGTH:   cca_flag = below_flag;
      rtom_pkg::RTOM_CCA_PKT:    cca_flag = ~rx_packet_active_i;
      rtom_pkg::RTOM_CCA_BOTH:   cca_flag = below_flag & ~rx_packet_active_i;
      default:                   cca_flag = 1'b1;
    endcase
  end

  // A result arriving with a receive restart wins, so it is not lost
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      crc_ok_reg <= 1'b0;
    end
    else if (crc_check_done_i)
    begin
      crc_ok_reg <= crc_check_pass_i;
    end
    else if (rx_mode_start_i)
    begin
      crc_ok_reg <= 1'b0;
    end
  end

  always_comb
  begin
    flags                = '0;
    flags[`RTOM_ST_PQ]    = pq_flag;
    flags[`RTOM_ST_CCA]   = cca_flag;
    flags[`RTOM_ST_CS]    = cs_flag;
    flags[`RTOM_ST_CRC]   = crc_ok_reg;
    flags[`RTOM_ST_HARD1] = rx_decided_bits_i[1];
    flags[`RTOM_ST_HARD0] = rx_decided_bits_i[0];
    flags[`RTOM_ST_TICK]  = rx_symbol_tick_i;
    flags[`RTOM_ST_PA_N]  = ~radio_in_tx_i;
    flags[`RTOM_ST_LNA_N] = ~radio_in_rx_i;
  end

  for (genvar g = 0; g < NUM_PINS; g++)
  begin : g_pin
    rtom_pin_sel u_sel (
      .sel_i        (test_output_select_reg[g]),
      .inv_i        (test_output_invert_reg[g]),
      .fsel_i       (fsel_reg[g]),
      .dir_i        (dir_reg[g]),
      .dout_i       (dout_reg[g]),
      .periph_out_i (periph_out_i[g]),
      .periph_oe_i  (periph_oe_i[g]),
      .flags_i      (flags),
      .out_next_o   (pin_out_next[g]),
      .oe_next_o    (pin_oe_next[g])
    );
  end

  // One cycle of latency on the pins buys glitch-free registered outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pin_out_reg <= '0;
      pin_oe_reg  <= '0;
    end
    else
    begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg  <= pin_oe_next;
    end
  end

  assign prdata_o  = prdata_reg;
  assign pready_o  = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign pin_out_o = pin_out_reg;
  assign pin_oe_o  = pin_oe_reg;

  property p_cfg_write;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (wr_fire && paddr_i == `RTOM_OFS_PIN1_CFG) |=>
        test_output_select_reg[1] == $past(pwdata_i[5:0]) ##1
        pin_oe_o[1] == (test_output_select_reg[1] != 6'h00 || $past(pin_oe_next[1]));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("pin1 config write not applied");

  property p_override;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[2] != 6'h00) |=> pin_oe_o[2];
  endproperty
  a_override: assert property (p_override)
    else $error("selected pin not driven");

  property p_port_mode;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[0] == 6'h00 && !fsel_reg[0]) |=>
        pin_oe_o[0] == $past(dir_reg[0]) && pin_out_o[0] == $past(dout_reg[0]);
  endproperty
  a_port_mode: assert property (p_port_mode)
    else $error("port path not followed with zero code");

  property p_pq;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[0] == 6'h08 && !test_output_invert_reg[0]) |=>
        pin_out_o[0] == ($past(preamble_quality_indicator_i) > $past(pqt_reg));
  endproperty
  a_pq: assert property (p_pq)
    else $error("preamble quality output wrong");

  property p_cca;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[1] == 6'h09 && !test_output_invert_reg[1] &&
       channel_assessment_mode_reg == rtom_pkg::RTOM_CCA_RECEIVED_SIGNAL_STRENGTH) |=>
        pin_out_o[1] == $past(below_flag);
  endproperty
  a_cca: assert property (p_cca)
    else $error("clear channel output wrong");

  property p_cs;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[2] == 6'h0E && test_output_invert_reg[2]) |=>
        pin_out_o[2] != $past(cs_flag);
  endproperty
  a_cs: assert property (p_cs)
    else $error("inverted carrier sense output wrong");

  property p_crc_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (rx_mode_start_i && !crc_check_done_i) ##1
        (test_output_select_reg[0] == 6'h0F && !test_output_invert_reg[0]) |=>
        !pin_out_o[0];
  endproperty
  a_crc_clear: assert property (p_crc_clear)
    else $error("checksum flag not cleared on receive start");

  property p_hard;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[1] == 6'h17 && !test_output_invert_reg[1]) |=>
        pin_out_o[1] == $past(rx_decided_bits_i[0]);
  endproperty
  a_hard: assert property (p_hard)
    else $error("decided bit 0 output wrong");

  property p_tick;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[2] == 6'h1D && !test_output_invert_reg[2] &&
       rx_symbol_tick_i) |=> pin_out_o[2] && pin_oe_o[2];
  endproperty
  a_tick: assert property (p_tick)
    else $error("symbol tick not output");

  property p_pa;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[0] == 6'h1B && !test_output_invert_reg[0]) |=>
        pin_out_o[0] == !$past(radio_in_tx_i);
  endproperty
  a_pa: assert property (p_pa)
    else $error("transmit amplifier control wrong");

  property p_lna;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[1] == 6'h1C && !test_output_invert_reg[1] &&
       radio_in_rx_i) |=> !pin_out_o[1];
  endproperty
  a_lna: assert property (p_lna)
    else $error("receive amplifier control not asserted");

  property p_const;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[2] == 6'h2F) |=>
        pin_out_o[2] == $past(test_output_invert_reg[2]);
  endproperty
  a_const: assert property (p_const)
    else $error("constant level wrong");

  property p_reserved;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (test_output_select_reg[0] == 6'h01) |=> !pin_out_o[0] && pin_oe_o[0];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code not driven low");

  property p_apb_ready;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (psel_i && penable_i && !pready_o) |=> pready_o ##1 !pready_o;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("bus ready not one cycle after access");
endmodule : rtom_top
`default_nettype wire

// *** rtom_map.svh ***
`ifndef RTOM_MAP_SVH
`define RTOM_MAP_SVH

`define RTOM_OFS_PIN0_CFG   12'h000
`define RTOM_OFS_PIN1_CFG   12'h004
`define RTOM_OFS_PIN2_CFG   12'h008
`define RTOM_OFS_THRESH     12'h00C
`define RTOM_OFS_PORT_CTRL  12'h010
`define RTOM_OFS_STATUS     12'h014

`define RTOM_CFG_SEL_LSB    0
`define RTOM_CFG_INV_BIT    6
`define RTOM_TH_PQT_LSB     0
`define RTOM_TH_RECEIVED_SIGNAL_STRENGTH_LSB    8
`define RTOM_TH_CCA_LSB     16
`define RTOM_PC_FSEL_LSB    0
`define RTOM_PC_DIR_LSB     4
`define RTOM_PC_DOUT_LSB    8
`define RTOM_ST_PIN_LSB     16

`define RTOM_ST_PQ          0
`define RTOM_ST_CCA         1
`define RTOM_ST_CS          2
`define RTOM_ST_CRC         3
`define RTOM_ST_HARD1       4
`define RTOM_ST_HARD0       5
`define RTOM_ST_TICK        6
`define RTOM_ST_PA_N        7
`define RTOM_ST_LNA_N       8
`define RTOM_NUM_FLAGS      9

`define RTOM_RST_SEL        6'h00
`define RTOM_RST_PQT        8'h00
`define RTOM_RST_RECEIVED_SIGNAL_STRENGTH_TH    8'h00
`define RTOM_RST_CCA        2'h0
`define RTOM_RST_PORT       3'h0

`endif

// *** rtom_pkg.sv ***
`default_nettype none
package rtom_pkg;
  typedef enum logic [5:0] {
    RTOM_SEL_PORT  = 6'h00,
    RTOM_SEL_PQ    = 6'h08,
    RTOM_SEL_CCA   = 6'h09,
    RTOM_SEL_CS    = 6'h0E,
    RTOM_SEL_CRC   = 6'h0F,
    RTOM_SEL_HARD1 = 6'h16,
    RTOM_SEL_HARD0 = 6'h17,
    RTOM_SEL_PA    = 6'h1B,
    RTOM_SEL_LNA   = 6'h1C,
    RTOM_SEL_TICK  = 6'h1D,
    RTOM_SEL_LOW   = 6'h2F
  } rtom_sel_type;

  typedef enum logic [1:0] {
    RTOM_CCA_ALWAYS = 2'h0,
    RTOM_CCA_RECEIVED_SIGNAL_STRENGTH   = 2'h1,
    RTOM_CCA_PKT    = 2'h2,
    RTOM_CCA_BOTH   = 2'h3
  } rtom_cca_type;
endpackage : rtom_pkg
`default_nettype wire

// *** rtom_pin_sel.sv ***
`include "rtom_map.svh"
`default_nettype none
module rtom_pin_sel (
  input  wire logic [5:0]                 sel_i,
  input  wire logic                       inv_i,
  input  wire logic                       fsel_i,
  input  wire logic                       dir_i,
  input  wire logic                       dout_i,
  input  wire logic                       periph_out_i,
  input  wire logic                       periph_oe_i,
  input  wire logic [`RTOM_NUM_FLAGS-1:0] flags_i,
  output logic                            out_next_o,
  output logic                            oe_next_o
);
  logic sig;

  always_comb
  begin
    case (sel_i)
      rtom_pkg::RTOM_SEL_PQ:    sig = flags_i[`RTOM_ST_PQ];
      rtom_pkg::RTOM_SEL_CCA:   sig = flags_i[`RTOM_ST_CCA];
      rtom_pkg::RTOM_SEL_CS:    sig = flags_i[`RTOM_ST_CS];
      rtom_pkg::RTOM_SEL_CRC:   sig = flags_i[`RTOM_ST_CRC];
      rtom_pkg::RTOM_SEL_HARD1: sig = flags_i[`RTOM_ST_HARD1];
      rtom_pkg::RTOM_SEL_HARD0: sig = flags_i[`RTOM_ST_HARD0];
      rtom_pkg::RTOM_SEL_TICK:  sig = flags_i[`RTOM_ST_TICK];
      rtom_pkg::RTOM_SEL_PA:    sig = flags_i[`RTOM_ST_PA_N];
      rtom_pkg::RTOM_SEL_LNA:   sig = flags_i[`RTOM_ST_LNA_N];
      rtom_pkg::RTOM_SEL_LOW:   sig = 1'b0;
      default:                  sig = 1'b0;
    endcase
  end

  always_comb
  begin
    if (sel_i == rtom_pkg::RTOM_SEL_PORT)
    begin
      // Normal port path: peripheral function wins over plain GPIO
      out_next_o = fsel_i ? periph_out_i : dout_i;
      oe_next_o  = fsel_i ? periph_oe_i : dir_i;
    end
    else if (sel_i == rtom_pkg::RTOM_SEL_LOW || sel_i == rtom_pkg::RTOM_SEL_PQ ||
             sel_i == rtom_pkg::RTOM_SEL_CCA || sel_i == rtom_pkg::RTOM_SEL_CS ||
             sel_i == rtom_pkg::RTOM_SEL_CRC || sel_i == rtom_pkg::RTOM_SEL_HARD1 ||
             sel_i == rtom_pkg::RTOM_SEL_HARD0 || sel_i == rtom_pkg::RTOM_SEL_TICK ||
             sel_i == rtom_pkg::RTOM_SEL_PA || sel_i == rtom_pkg::RTOM_SEL_LNA)
    begin
      out_next_o = sig ^ inv_i;
      oe_next_o  = 1'b1;
    end
    else
    begin
      // Reserved codes drive low, ignoring invert, so the pin stays predictable
      out_next_o = 1'b0;
      oe_next_o  = 1'b1;
    end
  end
endmodule : rtom_pin_sel
`default_nettype wire

// *** rtom_ext_model.sv ***
`default_nettype none
module rtom_ext_model (
  input  wire logic [2:0] pin_out_i,
  input  wire logic [2:0] pin_oe_i,
  output logic      [2:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Board pull-ups: a released pin reads high, never the last driven value
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pin_level_o[i] = pin_oe_i[i] ? pin_out_i[i] : 1'b1;
    end
  end
endmodule : rtom_ext_model
`default_nettype wire

// *** tb_radio_test_output_mux.sv ***
`include "rtom_map.svh"
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end
module tb_radio_test_output_mux;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i, psel_i, penable_i, pwrite_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic        pready_o, pslverr_o;
  logic [7:0]  preamble_quality_indicator, received_signal_strength;
  logic        pkt, crc_done, crc_pass, rx_start, tick, in_tx, in_rx;
  logic [1:0]  bits;
  logic [2:0]  periph_out, periph_oe, pin_level, pin_out_o, pin_oe_o;
  int          mismatches = 0;
  int          compares = 0;
  logic [31:0] rdv;
  logic        errv;

  always #2.5 sys_clk_i = ~sys_clk_i;

  rtom_top #(.NUM_PINS(3)) u_rtom_top (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .preamble_quality_indicator_i(preamble_quality_indicator),
    .received_signal_strength_i(received_signal_strength), .rx_packet_active_i(pkt),
    .crc_check_done_i(crc_done), .crc_check_pass_i(crc_pass), .rx_mode_start_i(rx_start),
    .rx_decided_bits_i(bits), .rx_symbol_tick_i(tick), .radio_in_tx_i(in_tx),
    .radio_in_rx_i(in_rx), .periph_out_i(periph_out), .periph_oe_i(periph_oe),
    .pin_in_i(pin_level), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));

  rtom_ext_model u_rtom_ext_model (
    .pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pin_level_o(pin_level));

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up

  // Request held until pready is sampled high; no latency assumed
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= wr;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 20);
    rdv  = prdata_o;
    errv = pslverr_o;
    if (n >= 20)
      `CHK(1'b0, 1'b1)
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic settle();
    repeat (3) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic set_sel(input int p, input logic [5:0] code, input logic inv);
    apb(1'b1, 12'(p * 4), {25'h0, inv, code});
    settle();
  endtask : set_sel

  task automatic t_reset();
    `CHK(pin_oe_o, 3'h0)
    for (int a = 0; a <= 16; a += 4)
    begin
      apb(1'b0, 12'(a), 32'h0);
      `CHK(rdv, 32'h0)
    end
    apb(1'b0, `RTOM_OFS_STATUS, 32'h0);
    `CHK(rdv[18:16], 3'h7)
  endtask : t_reset

  task automatic t_port();
    periph_out <= 3'h2;
    periph_oe  <= 3'h2;
    apb(1'b1, `RTOM_OFS_PORT_CTRL, 32'h0000_0112);
    settle();
    `CHK({pin_out_o[1:0], pin_oe_o}, 5'h1B)
    // Override must beat both the peripheral path and a zero direction
    @(posedge sys_clk_i);
    periph_oe <= 3'h0;
    set_sel(0, rtom_pkg::RTOM_SEL_LOW, 1'b1);
    set_sel(1, rtom_pkg::RTOM_SEL_LOW, 1'b0);
    set_sel(2, rtom_pkg::RTOM_SEL_LOW, 1'b1);
    `CHK({pin_out_o, pin_oe_o}, 6'h2F)
    set_sel(2, rtom_pkg::RTOM_SEL_PORT, 1'b0);
    `CHK(pin_oe_o[2], 1'b0)
  endtask : t_port

  task automatic t_levels();
    apb(1'b1, `RTOM_OFS_THRESH, 32'h0000_1040);
    set_sel(0, rtom_pkg::RTOM_SEL_PQ, 1'b0);
    // Inverted carrier sense also proves invert on a live signal
    set_sel(2, rtom_pkg::RTOM_SEL_CS, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk_i);
      preamble_quality_indicator  <= 8'h40 + 8'(i % 2);
      received_signal_strength <= (i < 4) ? 8'h10 + 8'(i % 2) : 8'hF0;
      settle();
      `CHK(pin_out_o[0], logic'(i % 2))
      `CHK(pin_out_o[2], logic'(!(i < 4 && i % 2 == 1)))
    end
  endtask : t_levels

  task automatic t_cca();
    logic exp;
    set_sel(1, rtom_pkg::RTOM_SEL_CCA, 1'b0);
    for (int m = 0; m < 4; m++)
    begin
      apb(1'b1, `RTOM_OFS_THRESH, 32'h0000_1000 | (m << 16));
      for (int k = 0; k < 4; k++)
      begin
        @(posedge sys_clk_i);
        received_signal_strength <= k[0] ? 8'h20 : 8'h05;
        pkt  <= k[1];
        settle();
        exp = (m[0] ? !k[0] : 1'b1) & (m[1] ? !k[1] : 1'b1);
        `CHK(pin_out_o[1], exp)
      end
    end
  endtask : t_cca

  task automatic pulse_crc(input logic done, input logic pass, input logic start);
    @(posedge sys_clk_i);
    crc_done <= done;
    crc_pass <= pass;
    rx_start <= start;
    @(posedge sys_clk_i);
    crc_done <= 1'b0;
    rx_start <= 1'b0;
    settle();
  endtask : pulse_crc

  task automatic t_crc();
    set_sel(0, rtom_pkg::RTOM_SEL_CRC, 1'b0);
    pulse_crc(1'b1, 1'b1, 1'b0);
    `CHK(pin_out_o[0], 1'b1)
    pulse_crc(1'b0, 1'b0, 1'b1);
    `CHK(pin_out_o[0], 1'b0)
    pulse_crc(1'b1, 1'b1, 1'b1);
    `CHK(pin_out_o[0], 1'b1)
    pulse_crc(1'b1, 1'b0, 1'b0);
    `CHK(pin_out_o[0], 1'b0)
  endtask : t_crc

  task automatic t_rx_amp();
    set_sel(0, rtom_pkg::RTOM_SEL_HARD1, 1'b0);
    set_sel(1, rtom_pkg::RTOM_SEL_HARD0, 1'b0);
    set_sel(2, rtom_pkg::RTOM_SEL_TICK, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      @(posedge sys_clk_i);
      bits <= 2'(k);
      tick <= k[0];
      settle();
      `CHK(pin_out_o, {k[0], k[0], k[1]})
    end
    set_sel(0, rtom_pkg::RTOM_SEL_PA, 1'b0);
    set_sel(1, rtom_pkg::RTOM_SEL_LNA, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge sys_clk_i);
      in_tx <= (k == 0);
      in_rx <= (k == 1);
      settle();
      `CHK(pin_out_o[1:0], 2'(k == 0 ? 2 : k == 1 ? 1 : 3))
    end
  endtask : t_rx_amp

  task automatic t_reserved_bus();
    logic [5:0] codes [4] = '{6'h01, 6'h0A, 6'h30, 6'h3F};
    foreach (codes[i])
    begin
      set_sel(0, codes[i], 1'b1);
      `CHK({pin_out_o[0], pin_oe_o[0]}, 2'h1)
    end
    apb(1'b1, `RTOM_OFS_PIN2_CFG, 32'hFFFF_FFEF);
    apb(1'b0, `RTOM_OFS_PIN2_CFG, 32'h0);
    `CHK(rdv, 32'h0000_006F)
    apb(1'b0, 12'h018, 32'h0);
    `CHK({errv, rdv}, 33'h1_0000_0000)
    apb(1'b1, 12'h018, 32'hFFFF_FFFF);
    `CHK(errv, 1'b1)
  endtask : t_reserved_bus

  initial
  begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {preamble_quality_indicator, received_signal_strength, pkt, crc_done, crc_pass, rx_start, bits, tick, in_tx, in_rx} = '0;
    {periph_out, periph_oe} = '0;
    rst_n_i = 1'b0;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    t_reset();
    t_port();
    t_levels();
    t_cca();
    t_crc();
    t_rx_amp();
    t_reserved_bus();
    wrap_up();
  end

  // About 350 cycles of traffic expected; ample margin before cutting a hang
  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    $display("unexpected at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_radio_test_output_mux
`default_nettype wire
